// [verilog/dsci_core.sv]
// Purpose: device side of a ddr2 sdram: command decode, banks, bursts
// Assumes: pad cells split each ddr pin into rise and fall halves
// Notes:   link logic runs on the true clock, registers on i_sys_clk
`timescale 1ns/1ps
module dsci_core
    import dsci_pkg::*;
(
    // system clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    // register port
    input  wire logic [3:0]  i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [31:0] o_reg_rdata,
    // link side
    input  wire logic        i_true_clock,
    input  wire dsci_cmd_s   i_cmd,
    input  wire dsci_wdat_s  i_wdat,
    output dsci_dq_s         o_link
);

    typedef struct packed {
        logic                   lower_only;
        logic [DSCI_STAT_W-1:0] st_s1;
        logic [DSCI_STAT_W-1:0] st_s2;
        logic [31:0]            rdata;
    } dsci_sys_s;

    typedef struct packed {
        logic                                ctrl_s1;
        logic                                ctrl_s2;
        logic [7:0]                          open;
        logic [7:0]                          row0;
        logic                                bl8;
        logic                                ilv;
        logic                                dll_on;
        dsci_pwr_e                           pwr;
        dsci_slot_s [DSCI_RD_LAT-1:0]        rd_line;
        dsci_slot_s [DSCI_WR_LAT-1:0]        wr_line;
        dsci_eng_s                           rd_eng;
        dsci_eng_s                           wr_eng;
        dsci_dq_s                            dq;
        logic [DSCI_STAT_W-1:0]              stat;
    } dsci_lnk_s;

    dsci_sys_s              s_q;
    dsci_sys_s              s_d;
    dsci_lnk_s              l_q;
    dsci_lnk_s              l_d;
    logic                   lrst_s1;
    logic                   lrst_n;
    logic [15:0]            mem [DSCI_MEM_DEPTH];
    dsci_cmd_e              cmd;
    dsci_slot_s             new_rd;
    dsci_slot_s             new_wr;
    dsci_slot_s             rd_head;
    dsci_slot_s             wr_head;
    dsci_eng_s              rd_cur;
    dsci_eng_s              wr_cur;
    logic [DSCI_MEM_AW-1:0] ridx0;
    logic [DSCI_MEM_AW-1:0] ridx1;
    logic [DSCI_MEM_AW-1:0] widx0;
    logic [DSCI_MEM_AW-1:0] widx1;
    logic [1:0]             wen0;
    logic [1:0]             wen1;
    logic                   lower_only;

    // register port: read data stand only in the cycle after the strobe
    always_comb begin
        s_d       = s_q;
        s_d.st_s1 = l_q.stat;
        s_d.st_s2 = s_q.st_s1;
        s_d.rdata = '0;
        if (i_reg_wr && i_reg_addr == DSCI_REG_CTRL) begin
            s_d.lower_only = i_reg_wdata[DSCI_CTRL_LOWER_ONLY];
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                DSCI_REG_CTRL:   s_d.rdata = {31'h0, s_q.lower_only};
                DSCI_REG_STATUS: s_d.rdata = {17'h0, s_q.st_s2};
                default:         s_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            s_q            <= '0;
            s_q.lower_only <= DSCI_RST_LOWER_ONLY;
        end else begin
            s_q <= s_d;
        end
    end

    // reset carried into the link domain through two flops
    always_ff @(posedge i_true_clock) begin
        lrst_s1 <= i_rst_n;
        lrst_n  <= lrst_s1;
    end

    // link logic; commands sampled only on the rising true clock
    always_comb begin
        l_d     = l_q;
        cmd     = dsci_decode(i_cmd);
        new_rd  = '0;
        new_wr  = '0;
        wen0    = '0;
        wen1    = '0;
        rd_head = l_q.rd_line[DSCI_RD_LAT-1];
        wr_head = l_q.wr_line[DSCI_WR_LAT-1];
        rd_cur  = l_q.rd_eng;
        wr_cur  = l_q.wr_eng;

        // lane control crosses from the register side
        l_d.ctrl_s1 = s_q.lower_only;
        l_d.ctrl_s2 = l_q.ctrl_s1;
        lower_only  = l_q.ctrl_s2;

        // a newly due read takes over: this is how bursts get cut short
        if (rd_head.vld) begin
            rd_cur = '{act: 1'b1, ap: rd_head.ap, bl8: l_q.bl8,
                       ilv: l_q.ilv, bank: rd_head.bank,
                       row0: rd_head.row0, col: rd_head.col,
                       beat: 3'h0};
        end
        // two beats per cycle: one 4n word every two cycles
        ridx0 = dsci_mem_idx(rd_cur.bank, rd_cur.row0,
                    dsci_beat_col(rd_cur.col, rd_cur.beat,
                                  rd_cur.bl8, rd_cur.ilv));
        ridx1 = dsci_mem_idx(rd_cur.bank, rd_cur.row0,
                    dsci_beat_col(rd_cur.col, {rd_cur.beat[2:1], 1'b1},
                                  rd_cur.bl8, rd_cur.ilv));
        l_d.rd_eng      = rd_cur;
        l_d.rd_eng.beat = 3'(rd_cur.beat + DSCI_BEAT_STEP);
        if (rd_cur.act && rd_cur.beat ==
                (rd_cur.bl8 ? DSCI_LAST_BL8 : DSCI_LAST_BL4)) begin
            l_d.rd_eng.act = 1'b0;
            if (rd_cur.ap) begin
                l_d.open[rd_cur.bank] = 1'b0;
            end
        end

        // read drive: strobe toggles with the data, lanes strobed apart
        l_d.dq = '0;
        if (rd_cur.act) begin
            l_d.dq.dq_rise              = mem[ridx0];
            l_d.dq.dq_fall              = mem[ridx1];
            l_d.dq.dq_oe                = {~lower_only, 1'b1};
            l_d.dq.lower_byte_strobe    = DSCI_STROBE_DATA;
            l_d.dq.lower_byte_strobe_oe = 1'b1;
            l_d.dq.upper_byte_strobe    = DSCI_STROBE_DATA;
            l_d.dq.upper_byte_strobe_oe = ~lower_only;
        end else if (l_q.rd_line[DSCI_RD_LAT-2].vld) begin
            // preamble: strobe driven low one cycle ahead of data
            l_d.dq.lower_byte_strobe    = DSCI_STROBE_PRE;
            l_d.dq.lower_byte_strobe_oe = 1'b1;
            l_d.dq.upper_byte_strobe    = DSCI_STROBE_PRE;
            l_d.dq.upper_byte_strobe_oe = ~lower_only;
        end

        // write engine, same structure as the read side
        if (wr_head.vld) begin
            wr_cur = '{act: 1'b1, ap: wr_head.ap, bl8: l_q.bl8,
                       ilv: l_q.ilv, bank: wr_head.bank,
                       row0: wr_head.row0, col: wr_head.col,
                       beat: 3'h0};
        end
        widx0 = dsci_mem_idx(wr_cur.bank, wr_cur.row0,
                    dsci_beat_col(wr_cur.col, wr_cur.beat,
                                  wr_cur.bl8, wr_cur.ilv));
        widx1 = dsci_mem_idx(wr_cur.bank, wr_cur.row0,
                    dsci_beat_col(wr_cur.col, {wr_cur.beat[2:1], 1'b1},
                                  wr_cur.bl8, wr_cur.ilv));
        // rise and fall halves both land: data from both strobe edges
        if (wr_cur.act) begin
            wen0 = {~i_wdat.upper_byte_mask[0] & ~lower_only,
                    ~i_wdat.lower_byte_mask[0]};
            wen1 = {~i_wdat.upper_byte_mask[1] & ~lower_only,
                    ~i_wdat.lower_byte_mask[1]};
        end
        l_d.wr_eng      = wr_cur;
        l_d.wr_eng.beat = 3'(wr_cur.beat + DSCI_BEAT_STEP);
        if (wr_cur.act && wr_cur.beat ==
                (wr_cur.bl8 ? DSCI_LAST_BL8 : DSCI_LAST_BL4)) begin
            l_d.wr_eng.act = 1'b0;
            if (wr_cur.ap) begin
                l_d.open[wr_cur.bank] = 1'b0;
            end
        end

        // commands last, so one to a bank wins over an ending precharge;
        // per-bank state lets one bank open while another bursts
        unique case (l_q.pwr)
            PWR_ACTIVE: begin
                if (!i_cmd.cke) begin
                    l_d.pwr = (cmd == CMD_REF) ? PWR_SELF_REF
                                               : PWR_DOWN;
                end else begin
                    unique case (cmd)
                        CMD_ACT: begin
                            l_d.open[i_cmd.ba] = 1'b1;
                            l_d.row0[i_cmd.ba] = i_cmd.addr[0];
                        end
                        CMD_PRE: begin
                            if (i_cmd.addr[DSCI_AP_BIT]) begin
                                l_d.open = '0;
                            end else begin
                                l_d.open[i_cmd.ba] = 1'b0;
                            end
                        end
                        CMD_RD: begin
                            // a closed bank is left alone
                            if (l_q.open[i_cmd.ba]) begin
                                new_rd = '{vld: 1'b1,
                                           ap: i_cmd.addr[DSCI_AP_BIT],
                                           bank: i_cmd.ba,
                                           row0: l_q.row0[i_cmd.ba],
                                           col: i_cmd.addr[4:0]};
                            end
                        end
                        CMD_WR: begin
                            if (l_q.open[i_cmd.ba]) begin
                                new_wr = '{vld: 1'b1,
                                           ap: i_cmd.addr[DSCI_AP_BIT],
                                           bank: i_cmd.ba,
                                           row0: l_q.row0[i_cmd.ba],
                                           col: i_cmd.addr[4:0]};
                            end
                        end
                        CMD_LMR: begin
                            if (i_cmd.ba == DSCI_BA_MR) begin
                                if (i_cmd.addr[2:0] == DSCI_MR_BL8) begin
                                    l_d.bl8 = 1'b1;
                                end else if (i_cmd.addr[2:0]
                                             == DSCI_MR_BL4) begin
                                    l_d.bl8 = 1'b0;
                                end
                                l_d.ilv = i_cmd.addr[DSCI_MR_BT_BIT];
                            end else if (i_cmd.ba == DSCI_BA_EMR) begin
                                l_d.dll_on =
                                    ~i_cmd.addr[DSCI_EMR_DLL_OFF_BIT];
                            end
                        end
                        CMD_DESEL, CMD_NOP, CMD_REF: begin
                        end
                    endcase
                end
            end
            // low-power states: every command ignored until cke rises
            PWR_DOWN, PWR_SELF_REF: begin
                if (i_cmd.cke) begin
                    l_d.pwr = PWR_ACTIVE;
                end
            end
            default: l_d.pwr = PWR_ACTIVE;
        endcase

        // latency lines; their heads load the engines
        l_d.rd_line = {l_q.rd_line[DSCI_RD_LAT-2:0], new_rd};
        l_d.wr_line = {l_q.wr_line[DSCI_WR_LAT-2:0], new_wr};

        // status word, registered here before it crosses over
        l_d.stat = '0;
        l_d.stat[DSCI_STAT_OPEN +: 8]   = l_q.open;
        l_d.stat[DSCI_STAT_SELF_REF]    = (l_q.pwr == PWR_SELF_REF);
        l_d.stat[DSCI_STAT_PDOWN]       = (l_q.pwr == PWR_DOWN);
        l_d.stat[DSCI_STAT_DLL]         = l_q.dll_on;
        l_d.stat[DSCI_STAT_BL8]         = l_q.bl8;
        l_d.stat[DSCI_STAT_ILV]         = l_q.ilv;
        l_d.stat[DSCI_STAT_RD_BUSY]     = l_q.rd_eng.act;
        l_d.stat[DSCI_STAT_WR_BUSY]     = l_q.wr_eng.act;
    end

    always_ff @(posedge i_true_clock) begin
        if (!lrst_n) begin
            l_q        <= '0;
            l_q.bl8    <= DSCI_RST_BL8;
            l_q.ilv    <= DSCI_RST_ILV;
            l_q.dll_on <= DSCI_RST_DLL_ON;
            l_q.pwr    <= PWR_ACTIVE;
        end else begin
            l_q <= l_d;
        end
    end

    // array write, per byte lane; content is not reset, as in a dram
    always_ff @(posedge i_true_clock) begin
        for (int b = 0; b < 2; b++) begin
            if (wen0[b]) begin
                mem[widx0][b*8 +: 8] <= i_wdat.dq_rise[b*8 +: 8];
            end
            if (wen1[b]) begin
                mem[widx1][b*8 +: 8] <= i_wdat.dq_fall[b*8 +: 8];
            end
        end
    end

    // outputs straight from flops
    assign o_reg_rdata = s_q.rdata;
    assign o_link      = l_q.dq;

endmodule : dsci_core

// [pkg/dsci_pkg.sv]
// Purpose: shared constants, types and helpers of the ddr2 core interface
// Assumes: x16 data path, small behavioural array, fixed latencies
// Notes:   field index 0 of per-lane vectors is the lower byte lane
package dsci_pkg;

    // geometry
    localparam int DSCI_MEM_AW    = 9;
    localparam int DSCI_MEM_DEPTH = 512;

    // pipeline latencies in link clock cycles
    localparam int DSCI_RD_LAT = 3;
    localparam int DSCI_WR_LAT = 2;

    // register offsets
    localparam logic [3:0] DSCI_REG_CTRL   = 4'h0;
    localparam logic [3:0] DSCI_REG_STATUS = 4'h4;

    // ctrl and status field positions
    localparam int DSCI_CTRL_LOWER_ONLY = 0;
    localparam int DSCI_STAT_W          = 15;
    localparam int DSCI_STAT_OPEN       = 0;
    localparam int DSCI_STAT_SELF_REF   = 8;
    localparam int DSCI_STAT_PDOWN      = 9;
    localparam int DSCI_STAT_DLL        = 10;
    localparam int DSCI_STAT_BL8        = 11;
    localparam int DSCI_STAT_ILV        = 12;
    localparam int DSCI_STAT_RD_BUSY    = 13;
    localparam int DSCI_STAT_WR_BUSY    = 14;

    // command address fields
    localparam int         DSCI_AP_BIT          = 10;
    localparam int         DSCI_MR_BT_BIT       = 3;
    localparam int         DSCI_EMR_DLL_OFF_BIT = 0;
    localparam logic [2:0] DSCI_MR_BL4          = 3'h2;
    localparam logic [2:0] DSCI_MR_BL8          = 3'h3;
    localparam logic [2:0] DSCI_BA_MR           = 3'h0;
    localparam logic [2:0] DSCI_BA_EMR          = 3'h1;

    // reset values
    localparam logic DSCI_RST_LOWER_ONLY = 1'b0;
    localparam logic DSCI_RST_BL8        = 1'b0;
    localparam logic DSCI_RST_ILV        = 1'b0;
    localparam logic DSCI_RST_DLL_ON     = 1'b1;

    // strobe pattern {fall half, rise half} and beat stepping
    localparam logic [1:0] DSCI_STROBE_DATA = 2'h1;
    localparam logic [1:0] DSCI_STROBE_PRE  = 2'h0;
    localparam logic [2:0] DSCI_LAST_BL4    = 3'h2;
    localparam logic [2:0] DSCI_LAST_BL8    = 3'h6;
    localparam logic [2:0] DSCI_BEAT_STEP   = 3'h2;

    typedef enum logic [2:0] {
        CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_LMR
    } dsci_cmd_e;

    typedef enum logic [1:0] {PWR_ACTIVE, PWR_DOWN, PWR_SELF_REF} dsci_pwr_e;

    typedef struct packed {
        logic        cke;
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [2:0]  ba;
        logic [13:0] addr;
    } dsci_cmd_s;

    // mask bit 0 qualifies the rise beat, bit 1 the fall beat
    typedef struct packed {
        logic [15:0] dq_rise;
        logic [15:0] dq_fall;
        logic [1:0]  lower_byte_mask;
        logic [1:0]  upper_byte_mask;
    } dsci_wdat_s;

    typedef struct packed {
        logic [15:0] dq_rise;
        logic [15:0] dq_fall;
        logic [1:0]  dq_oe;
        logic [1:0]  lower_byte_strobe;
        logic        lower_byte_strobe_oe;
        logic [1:0]  upper_byte_strobe;
        logic        upper_byte_strobe_oe;
    } dsci_dq_s;

    typedef struct packed {
        logic       vld;
        logic       ap;
        logic [2:0] bank;
        logic       row0;
        logic [4:0] col;
    } dsci_slot_s;

    typedef struct packed {
        logic       act;
        logic       ap;
        logic       bl8;
        logic       ilv;
        logic [2:0] bank;
        logic       row0;
        logic [4:0] col;
        logic [2:0] beat;
    } dsci_eng_s;

    function automatic dsci_cmd_e dsci_decode(input dsci_cmd_s c);
        if (c.cs_n) begin
            return CMD_DESEL;
        end
        case ({c.ras_n, c.cas_n, c.we_n})
            3'h3:    return CMD_ACT;
            3'h5:    return CMD_RD;
            3'h4:    return CMD_WR;
            3'h2:    return CMD_PRE;
            3'h1:    return CMD_REF;
            3'h0:    return CMD_LMR;
            default: return CMD_NOP;
        endcase
    endfunction : dsci_decode

    // column of beat i within a burst, sequential or interleaved
    function automatic logic [4:0] dsci_beat_col(input logic [4:0] start,
                                                 input logic [2:0] i,
                                                 input logic       bl8,
                                                 input logic       ilv);
        logic [2:0] o8;
        logic [1:0] o4;
        o8 = ilv ? (start[2:0] ^ i) : 3'(start[2:0] + i);
        o4 = ilv ? (start[1:0] ^ i[1:0]) : 2'(start[1:0] + i[1:0]);
        return bl8 ? {start[4:3], o8} : {start[4:2], o4};
    endfunction : dsci_beat_col

    function automatic logic [DSCI_MEM_AW-1:0] dsci_mem_idx(
        input logic [2:0] bank, input logic row0, input logic [4:0] col);
        return {bank, row0, col};
    endfunction : dsci_mem_idx

endpackage : dsci_pkg

// [test/dsci_core_sva.sv]
// Purpose: port checks of dsci_core
// Assumes: link side sampled on i_true_clock
// Notes:   lane mode mirrored from ctrl writes
`timescale 1ns/1ps
module dsci_core_sva
    import dsci_pkg::*;
(
    // watched ports
    input wire logic        i_sys_clk,
    input wire logic        i_rst_n,
    input wire logic [3:0]  i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [31:0] o_reg_rdata,
    input wire logic        i_true_clock,
    input wire dsci_cmd_s   i_cmd,
    input wire dsci_wdat_s  i_wdat,
    input wire dsci_dq_s    o_link
);
    logic lo_q;
    logic is_rd;
    logic mapped;
    // mirror is only valid while the link is quiet
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            lo_q <= 1'b0;
        end else if (i_reg_wr && i_reg_addr == DSCI_REG_CTRL) begin
            lo_q <= i_reg_wdata[DSCI_CTRL_LOWER_ONLY];
        end
    end
    // read command and address map decode
    assign is_rd = !i_cmd.cs_n && i_cmd.cke && i_cmd.ras_n && !i_cmd.cas_n
                   && i_cmd.we_n;
    assign mapped = i_reg_addr == DSCI_REG_CTRL
                    || i_reg_addr == DSCI_REG_STATUS;
    a_rdata_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    a_unmapped_zero: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) $past(i_reg_rd) && !$past(mapped)
        |-> o_reg_rdata == 32'h0) else $error("unmapped read not zero");
    a_status_upper: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) $past(i_reg_rd) && $past(i_reg_addr)
        == DSCI_REG_STATUS |-> o_reg_rdata[31:15] == 17'h0)
        else $error("status upper bits set");
    a_strobe_owner: assert property (@(posedge i_true_clock)
        disable iff (!i_rst_n) o_link.dq_oe[0] |-> o_link.lower_byte_strobe_oe)
        else $error("data driven without strobe");
    a_strobe_edge: assert property (@(posedge i_true_clock)
        disable iff (!i_rst_n) o_link.dq_oe[0]
        |-> o_link.lower_byte_strobe == DSCI_STROBE_DATA)
        else $error("strobe not aligned with data");
    a_upper_strobe: assert property (@(posedge i_true_clock)
        disable iff (!i_rst_n) o_link.dq_oe[1] |-> o_link.upper_byte_strobe_oe
        && o_link.upper_byte_strobe == DSCI_STROBE_DATA)
        else $error("upper lane strobe wrong");
    a_read_pream: assert property (@(posedge i_true_clock)
        disable iff (!i_rst_n) $rose(o_link.lower_byte_strobe_oe)
        |-> o_link.lower_byte_strobe == DSCI_STROBE_PRE ##1 o_link.dq_oe[0])
        else $error("missing read preamble");
    a_burst_pairs: assert property (@(posedge i_true_clock)
        disable iff (!i_rst_n) $rose(o_link.dq_oe[0]) |-> o_link.dq_oe[0][*2])
        else $error("burst shorter than two cycles");
    a_read_lat: assert property (@(posedge i_true_clock)
        disable iff (!i_rst_n) $rose(o_link.lower_byte_strobe_oe)
        |-> $past(is_rd, 3)) else $error("strobe without read");
    a_lane_pair: assert property (@(posedge i_true_clock)
        disable iff (!i_rst_n) o_link.dq_oe[1] == (o_link.dq_oe[0] && !lo_q))
        else $error("lane enables disagree");
    c_read: cover property (@(posedge i_true_clock) $rose(o_link.dq_oe[0]));
    c_lower: cover property (@(posedge i_true_clock) o_link.dq_oe == 2'h1);
    c_status: cover property (@(posedge i_sys_clk)
        $past(i_reg_rd) && o_reg_rdata != 32'h0);
endmodule : dsci_core_sva

bind dsci_core dsci_core_sva u_sva (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .i_true_clock(i_true_clock), .i_cmd(i_cmd), .i_wdat(i_wdat),
    .o_link(o_link));

// [test/dsci_ctrl_model.sv]
// Purpose: memory controller model on the link side
// Assumes: pad cells hand over captured write beats
// Notes:   released data lines show the inverted last value
`timescale 1ns/1ps
module dsci_ctrl_model
    import dsci_pkg::*;
(
    // link clock
    input  wire logic i_true_clock,
    // toward the device
    output dsci_cmd_s  o_cmd,
    output dsci_wdat_s o_wdat
);
    // idle bus at time zero, cke high
    initial begin
        o_cmd = {1'b1, 1'b0, 3'h7, 3'h0, 14'h0};
        o_wdat = '0;
    end
    // data of a column, known to the bench as well
    function automatic logic [15:0] pat(input logic [4:0] c);
        return {8'hA5, 3'h0, c};
    endfunction : pat
    // one command for one edge, then nop with cke held
    task automatic issue(input logic cke, input logic [2:0] rcw,
                         input logic [2:0] ba, input logic [13:0] a);
        @(posedge i_true_clock);
        o_cmd <= {cke, 1'b0, rcw, ba, a};
        @(posedge i_true_clock);
        o_cmd <= {cke, 1'b0, 3'h7, 3'h0, 14'h0};
    endtask : issue
    // write from column 0; beats stand as captured on both strobe edges
    task automatic wr(input logic [2:0] ba, input logic b8);
        issue(1'b1, 3'h4, ba, 14'h0);
        for (int k = 0; k < (b8 ? 8 : 4); k += 2) begin
            @(posedge i_true_clock);
            o_wdat <= {pat(5'(k)), pat(5'(k + 1)), 4'h0};
        end
        @(posedge i_true_clock);
        o_wdat <= ~o_wdat;
    endtask : wr
endmodule : dsci_ctrl_model

// [test/tb_dsci_core.sv]
// Purpose: self-checking bench of dsci_core
// Assumes: controller model drives the link side
// Notes:   status crosses domains, so it is read while quiet
`timescale 1ns/1ps
module tb_dsci_core
    import dsci_pkg::*;
;
    logic        sys_clk   = 1'b0;
    logic        lclk      = 1'b0;
    logic        rst_n     = 1'b0;
    logic [3:0]  reg_addr  = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] reg_rdata;
    dsci_cmd_s   cmd;
    dsci_wdat_s  wdat;
    dsci_dq_s    link;
    int          n_fail    = 0;
    int          n_tests   = 0;
    int          cycles    = 0;
    // rising edges of the two clocks never coincide
    always #4 sys_clk = ~sys_clk;
    always #16 lclk = ~lclk;
    dsci_core u_dut (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
        .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_true_clock(lclk),
        .i_cmd(cmd), .i_wdat(wdat), .o_link(link));
    dsci_ctrl_model u_ctrl (.i_true_clock(lclk), .o_cmd(cmd), .o_wdat(wdat));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic reg_wr_t(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_wr_t
    // data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        check(reg_rdata, exp);
    endtask : rd_chk
    task automatic st_chk(input logic [31:0] exp);
        repeat (16) @(posedge sys_clk);
        rd_chk(DSCI_REG_STATUS, exp);
    endtask : st_chk
    function automatic logic [4:0] col(input logic [4:0] s, input int i,
                                       input logic b8, input logic il);
        logic [4:0] m;
        logic [2:0] o;
        m = b8 ? 5'h07 : 5'h03;
        o = il ? (s[2:0] ^ 3'(i)) : 3'(s[2:0] + 3'(i));
        return (s & ~m) | ({2'h0, o} & m);
    endfunction : col
    // wait for data, then n beat pairs in burst order
    task automatic rd_burst(input logic [4:0] s, input int n, input logic b8,
        input logic il, input logic [1:0] oe, input logic [15:0] m);
        for (int k = 0; k < 12 && link.dq_oe === 2'h0; k++) @(negedge lclk);
        for (int i = 0; i < 2 * n; i += 2) begin
            check(32'(link.dq_oe), 32'(oe));
            check(32'(link.dq_rise & m),
                32'(u_ctrl.pat(col(s, i, b8, il)) & m));
            check(32'(link.dq_fall & m),
                32'(u_ctrl.pat(col(s, i + 1, b8, il)) & m));
            @(negedge lclk);
        end
    endtask : rd_burst
    task automatic t_regs();
        rd_chk(DSCI_REG_CTRL, 32'h0);
        rd_chk(DSCI_REG_STATUS, 32'h400);
        reg_wr_t(4'h8, 32'hFFFFFFFF);
        rd_chk(4'h8, 32'h0);
        reg_wr_t(DSCI_REG_CTRL, 32'h1);
        rd_chk(DSCI_REG_CTRL, 32'h1);
        reg_wr_t(DSCI_REG_CTRL, 32'h0);
    endtask : t_regs
    task automatic t_bl4();
        u_ctrl.issue(1'b1, 3'h0, 3'h0, 14'h2);
        u_ctrl.issue(1'b1, 3'h3, 3'h1, 14'h0);
        st_chk(32'h402);
        u_ctrl.wr(3'h1, 1'b0);
        u_ctrl.issue(1'b1, 3'h5, 3'h1, 14'h2);
        rd_burst(5'h2, 2, 1'b0, 1'b0, 2'h3, 16'hFFFF);
        check(32'(link.dq_oe), 32'h0);
    endtask : t_bl4
    // eight-beat interleaved read cut short by a second read
    task automatic t_bl8();
        u_ctrl.issue(1'b1, 3'h0, 3'h0, 14'hB);
        st_chk(32'h1C02);
        u_ctrl.wr(3'h1, 1'b1);
        u_ctrl.issue(1'b1, 3'h5, 3'h1, 14'h5);
        u_ctrl.issue(1'b1, 3'h5, 3'h1, 14'h0);
        rd_burst(5'h5, 2, 1'b1, 1'b1, 2'h3, 16'hFFFF);
        rd_burst(5'h0, 4, 1'b1, 1'b1, 2'h3, 16'hFFFF);
        check(32'(link.dq_oe), 32'h0);
    endtask : t_bl8
    // auto precharge read while another bank opens
    task automatic t_autopre();
        u_ctrl.issue(1'b1, 3'h5, 3'h1, 14'h400);
        u_ctrl.issue(1'b1, 3'h3, 3'h3, 14'h0);
        rd_burst(5'h0, 4, 1'b1, 1'b1, 2'h3, 16'hFFFF);
        st_chk(32'h1C08);
        u_ctrl.issue(1'b1, 3'h5, 3'h1, 14'h0);
        for (int k = 0; k < 8; k++) begin
            @(negedge lclk);
            check(32'(link.dq_oe), 32'h0);
        end
    endtask : t_autopre
    task automatic t_lower();
        reg_wr_t(DSCI_REG_CTRL, 32'h1);
        u_ctrl.issue(1'b1, 3'h3, 3'h1, 14'h0);
        u_ctrl.issue(1'b1, 3'h5, 3'h1, 14'h0);
        rd_burst(5'h0, 4, 1'b1, 1'b1, 2'h1, 16'h00FF);
        reg_wr_t(DSCI_REG_CTRL, 32'h0);
        u_ctrl.issue(1'b1, 3'h2, 3'h0, 14'h400);
        st_chk(32'h1C00);
    endtask : t_lower
    task automatic t_power();
        u_ctrl.issue(1'b0, 3'h7, 3'h0, 14'h0);
        st_chk(32'h1E00);
        u_ctrl.issue(1'b1, 3'h7, 3'h0, 14'h0);
        u_ctrl.issue(1'b0, 3'h1, 3'h0, 14'h0);
        st_chk(32'h1D00);
        u_ctrl.issue(1'b1, 3'h7, 3'h0, 14'h0);
        st_chk(32'h1C00);
    endtask : t_power
    // reset spans five link cycles so both domains see it
    initial begin
        repeat (5) @(posedge lclk);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge lclk);
        t_regs();
        t_bl4();
        t_bl8();
        t_autopre();
        t_lower();
        t_power();
        give_verdict();
    end
    // hang guard, far above the run length
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
endmodule : tb_dsci_core
